// >>> rfsc_regs.sv
/*
 * synthesiser and front-end configuration register bank: storage,
 * readback, field outputs, reference divider tick, alarm and sampler.
 * assumes a serial decoder gives one-cycle byte accesses; the main
 * register's reset bit arrives as main_reset_n_i.
 */
`timescale 1ns/10ps
module rfsc_regs (
   // clock and reset
   input  wire logic       mclk_i,
   input  wire logic       rst_n_i,
   // main register reset bit
   input  wire logic       main_reset_n_i,
   // configuration access
   input  wire logic [6:0] cfg_addr_i,
   input  wire logic       cfg_wr_i,
   input  wire logic       cfg_rd_i,
   input  wire logic [7:0] cfg_wdata_i,
   output logic      [7:0] cfg_rdata_o,
   output logic            cfg_rvalid_o,
   output logic            cfg_hit_o,
   // test and analog status inputs
   input  wire logic       break_loop_i,
   input  wire logic       fcomp_i,
   input  wire logic       alarm_high_raw_i,
   input  wire logic       alarm_low_raw_i,
   // synthesiser fields
   output logic      [7:0] separation_low_bits_o,
   output logic            loop_filter_select_o,
   output logic      [3:0] reference_divide_ratio_o,
   output logic            ref_tick_o,
   output logic            alarm_high_o,
   output logic            alarm_low_o,
   output logic            comp_sample_o,
   output logic            comp_sample_valid_o,
   // bias fields
   output logic      [3:0] osc_core_bias_o,
   output logic      [1:0] mixer_buffer_drive_o,
   output logic      [1:0] amp_buffer_drive_o,
   // front-end fields
   output logic            input_follower_stage_o,
   output logic      [1:0] input_amp_bias_o,
   output logic      [1:0] analog_pin_select_o,
   output logic            rssi_enable_o,
   output logic            internal_if_off_o,
   output logic            crystal_osc_off_o,
   // amplifier fields
   output logic      [3:0] high_array_level_o,
   output logic      [3:0] low_array_level_o
);
   typedef struct packed {
      logic [7:0] sep;
      logic [7:0] bias;
      logic [5:0] front;
      logic [7:0] pa;
      logic [5:0] pll;
      logic [7:0] rdata;
      logic       rvalid;
      logic       hit;
      logic [3:0] div_cnt;
      logic       tick;
   } rfsc_state_t;

   rfsc_state_t r;
   rfsc_state_t next_r;

   logic       alm_hi;
   logic       alm_lo;
   logic       wr_pll;
   logic [3:0] div_eff;

   function automatic logic sel(input logic [6:0] a,
                                input logic [6:0] off);
      sel = (a == off);
   endfunction : sel

   assign wr_pll = cfg_wr_i & main_reset_n_i &
                   sel(cfg_addr_i, rfsc_pkg::PLL_ADDR);

   // forbidden ratios run as the smallest legal one
   assign div_eff = (r.pll[rfsc_pkg::DIV_MSB-rfsc_pkg::PLLW_LSB:
                           rfsc_pkg::DIV_LSB-rfsc_pkg::PLLW_LSB]
                     < rfsc_pkg::DIV_MIN) ? rfsc_pkg::DIV_MIN :
                    r.pll[rfsc_pkg::DIV_MSB-rfsc_pkg::PLLW_LSB:
                          rfsc_pkg::DIV_LSB-rfsc_pkg::PLLW_LSB];

   always_comb begin
      next_r        = r;
      next_r.rvalid = cfg_rd_i;
      next_r.hit    = 1'b0;
      next_r.rdata  = 8'h00;
      if (!main_reset_n_i) begin
         // defaults held until the reset bit returns high
         next_r.sep   = rfsc_pkg::SEP_LOW_RST;
         next_r.bias  = rfsc_pkg::BIAS_RST;
         next_r.front = rfsc_pkg::FRONT_RST;
         next_r.pa    = rfsc_pkg::PA_RST;
         next_r.pll   = rfsc_pkg::PLL_RST;
      end else if (cfg_wr_i) begin
         if (sel(cfg_addr_i, rfsc_pkg::SEP_LOW_ADDR)) begin
            next_r.sep = cfg_wdata_i;
         end
         if (sel(cfg_addr_i, rfsc_pkg::BIAS_ADDR)) begin
            next_r.bias = cfg_wdata_i;
         end
         if (sel(cfg_addr_i, rfsc_pkg::FRONT_ADDR)) begin
            next_r.front = cfg_wdata_i[rfsc_pkg::FRONT_W-1:0];
         end
         if (sel(cfg_addr_i, rfsc_pkg::PA_ADDR)) begin
            next_r.pa = cfg_wdata_i;
         end
         if (sel(cfg_addr_i, rfsc_pkg::PLL_ADDR)) begin
            // alarm bits are not stored
            next_r.pll = cfg_wdata_i[7:rfsc_pkg::PLLW_LSB];
         end
      end
      if (cfg_rd_i) begin
         next_r.hit = 1'b1;
         case (1'b1)
            sel(cfg_addr_i, rfsc_pkg::SEP_LOW_ADDR): begin
               next_r.rdata = r.sep;
            end
            sel(cfg_addr_i, rfsc_pkg::BIAS_ADDR): begin
               next_r.rdata = r.bias;
            end
            sel(cfg_addr_i, rfsc_pkg::FRONT_ADDR): begin
               next_r.rdata = {2'h0, r.front};
            end
            sel(cfg_addr_i, rfsc_pkg::PA_ADDR): begin
               next_r.rdata = r.pa;
            end
            sel(cfg_addr_i, rfsc_pkg::PLL_ADDR): begin
               next_r.rdata = {r.pll, alm_hi, alm_lo};
            end
            default: begin
               next_r.hit = 1'b0;
            end
         endcase
      end
      // reference divider: one-cycle tick every div_eff cycles
      if (r.div_cnt >= div_eff - rfsc_pkg::DIV_ONE) begin
         next_r.div_cnt = 4'h0;
         next_r.tick    = 1'b1;
      end else begin
         next_r.div_cnt = r.div_cnt + rfsc_pkg::DIV_ONE;
         next_r.tick    = 1'b0;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         r       <= '0;
         r.sep   <= rfsc_pkg::SEP_LOW_RST;
         r.bias  <= rfsc_pkg::BIAS_RST;
         r.front <= rfsc_pkg::FRONT_RST;
         r.pa    <= rfsc_pkg::PA_RST;
         r.pll   <= rfsc_pkg::PLL_RST;
      end else begin
         r <= next_r;
      end
   end

   rfsc_alarm u_alarm (
      .mclk_i       (mclk_i),
      .rst_n_i      (rst_n_i),
      .disable_i    (r.pll[rfsc_pkg::ADIS_BIT-rfsc_pkg::PLLW_LSB]),
      .high_raw_i   (alarm_high_raw_i),
      .low_raw_i    (alarm_low_raw_i),
      .alarm_high_o (alm_hi),
      .alarm_low_o  (alm_lo)
   );

   rfsc_comp_sample u_comp (
      .mclk_i         (mclk_i),
      .rst_n_i        (rst_n_i),
      .wr_i           (wr_pll),
      .old_filt_i     (r.pll[rfsc_pkg::FILT_BIT-rfsc_pkg::PLLW_LSB]),
      .new_filt_i     (cfg_wdata_i[rfsc_pkg::FILT_BIT]),
      .break_loop_i   (break_loop_i),
      .fcomp_i        (fcomp_i),
      .sample_o       (comp_sample_o),
      .sample_valid_o (comp_sample_valid_o)
   );

   // access answers
   assign cfg_rdata_o  = r.rdata;
   assign cfg_rvalid_o = r.rvalid;
   assign cfg_hit_o    = r.hit;

   // field outputs
   assign separation_low_bits_o = r.sep;
   assign osc_core_bias_o =
      r.bias[rfsc_pkg::OSC_MSB:rfsc_pkg::OSC_LSB];
   assign mixer_buffer_drive_o =
      r.bias[rfsc_pkg::MIX_MSB:rfsc_pkg::MIX_LSB];
   assign amp_buffer_drive_o =
      r.bias[rfsc_pkg::AMPB_MSB:rfsc_pkg::AMPB_LSB];
   assign input_follower_stage_o = r.front[rfsc_pkg::FOLLOW_BIT];
   assign input_amp_bias_o =
      r.front[rfsc_pkg::LNA_MSB:rfsc_pkg::LNA_LSB];
   assign analog_pin_select_o =
      r.front[rfsc_pkg::PIN_MSB:rfsc_pkg::PIN_LSB];
   assign rssi_enable_o =
      (analog_pin_select_o == rfsc_pkg::PIN_RSSI);
   assign internal_if_off_o =
      (analog_pin_select_o == rfsc_pkg::PIN_MIXER);
   assign crystal_osc_off_o = r.front[rfsc_pkg::XOSC_BIT];
   assign high_array_level_o =
      r.pa[rfsc_pkg::HI_MSB:rfsc_pkg::HI_LSB];
   assign low_array_level_o =
      r.pa[rfsc_pkg::LO_MSB:rfsc_pkg::LO_LSB];
   assign loop_filter_select_o =
      r.pll[rfsc_pkg::FILT_BIT-rfsc_pkg::PLLW_LSB];
   assign reference_divide_ratio_o =
      r.pll[rfsc_pkg::DIV_MSB-rfsc_pkg::PLLW_LSB:
            rfsc_pkg::DIV_LSB-rfsc_pkg::PLLW_LSB];
   assign ref_tick_o   = r.tick;
   assign alarm_high_o = alm_hi;
   assign alarm_low_o  = alm_lo;

   a_sep_default: assert property (
      @(posedge mclk_i) disable iff (!rst_n_i)
      !main_reset_n_i |=> separation_low_bits_o == 8'h59)
      else $error("separation low byte default wrong");
   a_bias_default: assert property (
      @(posedge mclk_i) disable iff (!rst_n_i)
      !main_reset_n_i |=> osc_core_bias_o == 4'hc &&
                          mixer_buffer_drive_o == 2'h2 &&
                          amp_buffer_drive_o == 2'h2)
      else $error("bias defaults wrong");
   a_front_default: assert property (
      @(posedge mclk_i) disable iff (!rst_n_i)
      !main_reset_n_i |=> input_amp_bias_o == 2'h1 &&
                          !input_follower_stage_o &&
                          analog_pin_select_o == 2'h0 &&
                          !crystal_osc_off_o)
      else $error("front-end defaults wrong");
   a_amp_default: assert property (
      @(posedge mclk_i) disable iff (!rst_n_i)
      !main_reset_n_i |=> high_array_level_o == 4'h0 &&
                          low_array_level_o == 4'hf)
      else $error("amplifier level defaults wrong");
   a_synth_default: assert property (
      @(posedge mclk_i) disable iff (!rst_n_i)
      !main_reset_n_i |=> reference_divide_ratio_o == 4'h2 &&
                          !loop_filter_select_o)
      else $error("synthesiser defaults wrong");
   a_reset_holds: assert property (
      @(posedge mclk_i) disable iff (!rst_n_i)
      !main_reset_n_i && cfg_wr_i |=> separation_low_bits_o == 8'h59)
      else $error("write accepted while reset bit low");
   a_front_readback: assert property (
      @(posedge mclk_i) disable iff (!rst_n_i)
      main_reset_n_i && cfg_wr_i && cfg_addr_i == 7'h0a
      ##1 main_reset_n_i && !cfg_wr_i
      ##1 cfg_rd_i && cfg_addr_i == 7'h0a && !cfg_wr_i
      |=> cfg_rdata_o == ($past(cfg_wdata_i, 3) & 8'h3f))
      else $error("front-end readback wrong");
   a_alarm_readonly: assert property (
      @(posedge mclk_i) disable iff (!rst_n_i)
      cfg_rd_i && cfg_addr_i == 7'h0c
      |=> cfg_rdata_o[1:0] == {$past(alm_hi), $past(alm_lo)})
      else $error("alarm bits not read from status");
   a_pin_decode: assert property (
      @(posedge mclk_i) disable iff (!rst_n_i)
      internal_if_off_o |-> analog_pin_select_o == 2'h2 &&
                            !rssi_enable_o)
      else $error("analog pin decode wrong");
   a_tick_spacing: assert property (
      @(posedge mclk_i) disable iff (!rst_n_i)
      ref_tick_o |=> !ref_tick_o)
      else $error("reference tick closer than two cycles");
   a_unmapped_zero: assert property (
      @(posedge mclk_i) disable iff (!rst_n_i)
      cfg_rd_i && (cfg_addr_i < 7'h08 || cfg_addr_i > 7'h0c)
      |=> !cfg_hit_o && cfg_rdata_o == 8'h00)
      else $error("unmapped read not zero");
   a_sep_write: assert property (
      @(posedge mclk_i) disable iff (!rst_n_i)
      main_reset_n_i && cfg_wr_i && cfg_addr_i == 7'h08
      |=> separation_low_bits_o == $past(cfg_wdata_i))
      else $error("separation write lost");
   a_bias_write: assert property (
      @(posedge mclk_i) disable iff (!rst_n_i)
      main_reset_n_i && cfg_wr_i && cfg_addr_i == 7'h09
      |=> {osc_core_bias_o, mixer_buffer_drive_o,
           amp_buffer_drive_o} == $past(cfg_wdata_i))
      else $error("bias write lost");
   a_front_write: assert property (
      @(posedge mclk_i) disable iff (!rst_n_i)
      main_reset_n_i && cfg_wr_i && cfg_addr_i == 7'h0a
      |=> {input_follower_stage_o, input_amp_bias_o, analog_pin_select_o,
           crystal_osc_off_o} == $past(cfg_wdata_i[5:0]))
      else $error("front-end write lost");
   a_amp_write: assert property (
      @(posedge mclk_i) disable iff (!rst_n_i)
      main_reset_n_i && cfg_wr_i && cfg_addr_i == 7'h0b
      |=> {high_array_level_o, low_array_level_o} == $past(cfg_wdata_i))
      else $error("amplifier level write lost");
   a_synth_write: assert property (
      @(posedge mclk_i) disable iff (!rst_n_i)
      main_reset_n_i && cfg_wr_i && cfg_addr_i == 7'h0c
      |=> {loop_filter_select_o, reference_divide_ratio_o} ==
          $past(cfg_wdata_i[7:3]))
      else $error("synthesiser write lost");
   a_read_answer: assert property (
      @(posedge mclk_i) disable iff (!rst_n_i)
      cfg_rd_i |=> cfg_rvalid_o)
      else $error("read not answered");
   a_read_idle: assert property (
      @(posedge mclk_i) disable iff (!rst_n_i)
      !cfg_rd_i |=> !cfg_rvalid_o && !cfg_hit_o)
      else $error("answer without read");
   a_rssi_decode: assert property (
      @(posedge mclk_i) disable iff (!rst_n_i)
      rssi_enable_o |-> analog_pin_select_o == 2'h1 && !internal_if_off_o)
      else $error("rssi decode wrong");
   a_sep_readback: assert property (
      @(posedge mclk_i) disable iff (!rst_n_i)
      cfg_rd_i && cfg_addr_i == 7'h08
      |=> cfg_hit_o && cfg_rdata_o == $past(separation_low_bits_o))
      else $error("separation readback wrong");
   a_bias_readback: assert property (
      @(posedge mclk_i) disable iff (!rst_n_i)
      cfg_rd_i && cfg_addr_i == 7'h09
      |=> cfg_rdata_o[7:4] == $past(osc_core_bias_o) &&
          cfg_rdata_o[3:2] == $past(mixer_buffer_drive_o) &&
          cfg_rdata_o[1:0] == $past(amp_buffer_drive_o))
      else $error("bias readback wrong");
   a_amp_readback: assert property (
      @(posedge mclk_i) disable iff (!rst_n_i)
      cfg_rd_i && cfg_addr_i == 7'h0b
      |=> cfg_rdata_o[7:4] == $past(high_array_level_o) &&
          cfg_rdata_o[3:0] == $past(low_array_level_o))
      else $error("amplifier level readback wrong");
   a_pll_readback: assert property (
      @(posedge mclk_i) disable iff (!rst_n_i)
      cfg_rd_i && cfg_addr_i == 7'h0c
      |=> cfg_rdata_o[7] == $past(loop_filter_select_o) &&
          cfg_rdata_o[6:3] == $past(reference_divide_ratio_o))
      else $error("synthesiser readback wrong");
   a_sample_refused: assert property (
      @(posedge mclk_i) disable iff (!rst_n_i)
      !main_reset_n_i |=> !comp_sample_valid_o)
      else $error("sample taken during main reset");
endmodule : rfsc_regs

// >>> rfsc_pkg.sv
/*
 * constants for the synthesiser and front-end configuration registers:
 * offsets, field positions, widths and reset values.
 * assumes an outer serial decoder presents byte-wide register accesses.
 */
package rfsc_pkg;
   // register offsets
   localparam logic [6:0] SEP_LOW_ADDR = 7'h08;
   localparam logic [6:0] BIAS_ADDR    = 7'h09;
   localparam logic [6:0] FRONT_ADDR   = 7'h0a;
   localparam logic [6:0] PA_ADDR      = 7'h0b;
   localparam logic [6:0] PLL_ADDR     = 7'h0c;
   // reset values
   localparam logic [7:0] SEP_LOW_RST  = 8'h59;
   localparam logic [7:0] BIAS_RST     = 8'hca;
   localparam logic [5:0] FRONT_RST    = 6'h08;
   localparam logic [7:0] PA_RST       = 8'h0f;
   localparam logic [5:0] PLL_RST      = 6'h04;
   // field positions
   localparam int OSC_MSB     = 7;
   localparam int OSC_LSB     = 4;
   localparam int MIX_MSB     = 3;
   localparam int MIX_LSB     = 2;
   localparam int AMPB_MSB    = 1;
   localparam int AMPB_LSB    = 0;
   localparam int FOLLOW_BIT  = 5;
   localparam int LNA_MSB     = 4;
   localparam int LNA_LSB     = 3;
   localparam int PIN_MSB     = 2;
   localparam int PIN_LSB     = 1;
   localparam int XOSC_BIT    = 0;
   localparam int HI_MSB      = 7;
   localparam int HI_LSB      = 4;
   localparam int LO_MSB      = 3;
   localparam int LO_LSB      = 0;
   localparam int FILT_BIT    = 7;
   localparam int DIV_MSB     = 6;
   localparam int DIV_LSB     = 3;
   localparam int ADIS_BIT    = 2;
   localparam int ALH_BIT     = 1;
   localparam int ALL_BIT     = 0;
   localparam int FRONT_W     = 6;
   localparam int PLLW_LSB    = 2;
   // analog pin codes
   localparam logic [1:0] PIN_RSSI  = 2'h1;
   localparam logic [1:0] PIN_MIXER = 2'h2;
   // reference divider
   localparam logic [3:0] DIV_MIN   = 4'h2;
   localparam logic [3:0] DIV_ONE   = 4'h1;
endpackage : rfsc_pkg

// >>> rfsc_alarm.sv
/*
 * tuning-voltage alarm status capture with disable gating.
 * assumes the raw comparator levels are synchronous to mclk_i.
 */
`timescale 1ns/10ps
module rfsc_alarm (
   // clock and reset
   input  wire logic mclk_i,
   input  wire logic rst_n_i,
   // control and raw levels
   input  wire logic disable_i,
   input  wire logic high_raw_i,
   input  wire logic low_raw_i,
   // status
   output logic      alarm_high_o,
   output logic      alarm_low_o
);
   typedef struct packed {
      logic hi;
      logic lo;
   } rfsc_alarm_t;

   rfsc_alarm_t r;
   rfsc_alarm_t next_r;

   always_comb begin
      next_r    = r;
      next_r.hi = high_raw_i & ~disable_i;
      next_r.lo = low_raw_i & ~disable_i;
   end

   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign alarm_high_o = r.hi;
   assign alarm_low_o  = r.lo;

   a_alarm_high_follow: assert property (
      @(posedge mclk_i) disable iff (!rst_n_i)
      high_raw_i && !disable_i |=> alarm_high_o)
      else $error("high alarm not reported");
   a_alarm_low_follow: assert property (
      @(posedge mclk_i) disable iff (!rst_n_i)
      low_raw_i && !disable_i |=> alarm_low_o)
      else $error("low alarm not reported");
   a_alarm_disabled: assert property (
      @(posedge mclk_i) disable iff (!rst_n_i)
      disable_i |=> !alarm_high_o && !alarm_low_o)
      else $error("alarm shown while disabled");
endmodule : rfsc_alarm

// >>> rfsc_comp_sample.sv
/*
 * frequency comparator sampler for loop-break test mode.
 * assumes the write pulse carries old and new filter-select values.
 */
`timescale 1ns/10ps
module rfsc_comp_sample (
   // clock and reset
   input  wire logic mclk_i,
   input  wire logic rst_n_i,
   // write event
   input  wire logic wr_i,
   input  wire logic old_filt_i,
   input  wire logic new_filt_i,
   // test inputs
   input  wire logic break_loop_i,
   input  wire logic fcomp_i,
   // sample
   output logic      sample_o,
   output logic      sample_valid_o
);
   typedef struct packed {
      logic smp;
      logic vld;
   } rfsc_cs_t;

   rfsc_cs_t r;
   rfsc_cs_t next_r;
   logic     fall;

   assign fall = wr_i & old_filt_i & ~new_filt_i & break_loop_i;

   always_comb begin
      next_r     = r;
      next_r.vld = fall;
      if (fall) begin
         next_r.smp = fcomp_i;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign sample_o       = r.smp;
   assign sample_valid_o = r.vld;

   a_comp_sampled: assert property (
      @(posedge mclk_i) disable iff (!rst_n_i)
      fall |=> sample_valid_o && sample_o == $past(fcomp_i))
      else $error("comparator not sampled on falling write");
   a_comp_hold: assert property (
      @(posedge mclk_i) disable iff (!rst_n_i)
      !fall |=> $stable(sample_o) && !sample_valid_o)
      else $error("sample changed without falling write");
endmodule : rfsc_comp_sample

// >>> rfsc_host_model.sv
/*
 * host-side model of the configuration port: byte writes and reads.
 * assumes the bench calls its tasks only after reset is released.
 */
`timescale 1ns/10ps
module rfsc_host_model (
   // clock
   input  wire logic       mclk_i,
   // configuration access
   output logic      [6:0] cfg_addr_o,
   output logic            cfg_wr_o,
   output logic            cfg_rd_o,
   output logic      [7:0] cfg_wdata_o
);
   initial begin
      cfg_addr_o  = 7'h00;
      cfg_wr_o    = 1'b0;
      cfg_rd_o    = 1'b0;
      cfg_wdata_o = 8'h00;
   end

   // one-cycle strobe; data parked inverted so stale values never match
   task automatic write(input logic [6:0] a, input logic [7:0] wd);
      @(posedge mclk_i);
      cfg_addr_o  <= a;
      cfg_wdata_o <= wd;
      cfg_wr_o    <= 1'b1;
      @(posedge mclk_i);
      cfg_wr_o    <= 1'b0;
      cfg_wdata_o <= ~wd;
   endtask : write

   task automatic read(input logic [6:0] a);
      @(posedge mclk_i);
      cfg_addr_o <= a;
      cfg_rd_o   <= 1'b1;
      @(posedge mclk_i);
      cfg_rd_o   <= 1'b0;
   endtask : read

   // amplifier levels to zero before power-down
   task automatic power_down();
      write(rfsc_pkg::PA_ADDR, 8'h00);
   endtask : power_down
endmodule : rfsc_host_model

// >>> rfsc_regs_tb_top.sv
/*
 * self-checking bench for the configuration register bank.
 * assumes the host model drives the access port; reads are scored
 * from a queue of expected replies by a separate monitor.
 */
`timescale 1ns/10ps
module rfsc_regs_tb_top;
   logic       mclk_i = 1'b0;
   logic       rst_n_i = 1'b0;
   logic       main_reset_n_i = 1'b1;
   logic       break_loop_i = 1'b0;
   logic       fcomp_i = 1'b0;
   logic       alarm_high_raw_i = 1'b0;
   logic       alarm_low_raw_i = 1'b0;
   logic [6:0] cfg_addr_i;
   logic       cfg_wr_i, cfg_rd_i, cfg_rvalid_o, cfg_hit_o;
   logic [7:0] cfg_wdata_i, cfg_rdata_o, separation_low_bits_o, d;
   logic       loop_filter_select_o, ref_tick_o, alarm_high_o, alarm_low_o;
   logic       comp_sample_o, comp_sample_valid_o, input_follower_stage_o;
   logic [3:0] reference_divide_ratio_o, osc_core_bias_o;
   logic [3:0] high_array_level_o, low_array_level_o;
   logic [1:0] mixer_buffer_drive_o, amp_buffer_drive_o;
   logic [1:0] input_amp_bias_o, analog_pin_select_o;
   logic       rssi_enable_o, internal_if_off_o, crystal_osc_off_o;
   logic [8:0] exp_q[$];
   logic [8:0] note;
   int         n_errors = 0;
   int         checks = 0;
   int         c;
   // divider codes and the periods they give; codes 0 and 1 run as 2
   logic [3:0] c_tab[4] = '{4'h2, 4'h5, 4'hf, 4'h0};
   logic [7:0] n_tab[4] = '{8'h02, 8'h05, 8'h0f, 8'h02};

   always #20 mclk_i = ~mclk_i;

   rfsc_host_model i_rfsc_host_model (.mclk_i(mclk_i),
      .cfg_addr_o(cfg_addr_i), .cfg_wr_o(cfg_wr_i),
      .cfg_rd_o(cfg_rd_i), .cfg_wdata_o(cfg_wdata_i));

   rfsc_regs i_rfsc_regs (.mclk_i, .rst_n_i, .main_reset_n_i,
      .cfg_addr_i, .cfg_wr_i, .cfg_rd_i, .cfg_wdata_i, .cfg_rdata_o,
      .cfg_rvalid_o, .cfg_hit_o, .break_loop_i, .fcomp_i,
      .alarm_high_raw_i, .alarm_low_raw_i, .separation_low_bits_o,
      .loop_filter_select_o, .reference_divide_ratio_o, .ref_tick_o,
      .alarm_high_o, .alarm_low_o, .comp_sample_o, .comp_sample_valid_o,
      .osc_core_bias_o, .mixer_buffer_drive_o, .amp_buffer_drive_o,
      .input_follower_stage_o, .input_amp_bias_o, .analog_pin_select_o,
      .rssi_enable_o, .internal_if_off_o, .crystal_osc_off_o,
      .high_array_level_o, .low_array_level_o);

   task automatic final_report();
      $display("checks %0d mismatches %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : final_report

   task automatic chk(input string nm, input logic [7:0] e,
                      input logic [7:0] g);
      checks++;
      if (g !== e) begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   task automatic rd_chk(input logic [6:0] a, input logic [7:0] e,
                         input logic hit);
      exp_q.push_back({hit, e});
      i_rfsc_host_model.read(a);
   endtask : rd_chk

   task automatic defaults_chk();
      rd_chk(rfsc_pkg::SEP_LOW_ADDR, 8'h59, 1'b1);
      rd_chk(rfsc_pkg::BIAS_ADDR, 8'hca, 1'b1);
      rd_chk(rfsc_pkg::FRONT_ADDR, 8'h08, 1'b1);
      rd_chk(rfsc_pkg::PA_ADDR, 8'h0f, 1'b1);
      rd_chk(rfsc_pkg::PLL_ADDR, 8'h10, 1'b1);
   endtask : defaults_chk

   // edges counted up to and including the next tick
   task automatic wait_tick(output int n);
      n = 0;
      do begin
         @(posedge mclk_i);
         n++;
      end while (ref_tick_o !== 1'b1 && n < 40);
      if (ref_tick_o !== 1'b1) begin
         n_errors++;
         $display("mismatch tick expected 1 seen %b", ref_tick_o);
         final_report();
      end
   endtask : wait_tick

   // read replies scored oldest first
   always @(posedge mclk_i) begin
      if (cfg_rvalid_o === 1'b1) begin
         if (exp_q.size() == 0) begin
            chk("rvalid", 8'h00, 8'h01);
         end else begin
            note = exp_q.pop_front();
            chk("rdata", note[7:0], cfg_rdata_o);
            chk("hit", {7'h00, note[8]}, {7'h00, cfg_hit_o});
         end
      end
   end

   initial begin
      #2000000;
      n_errors++;
      $display("mismatch watchdog expected end seen hang");
      final_report();
   end

   initial begin
      void'($urandom(16));
      repeat (20) @(posedge mclk_i);
      rst_n_i <= 1'b1;
      defaults_chk();
      $display("test defaults done");
      for (int i = 0; i < 8; i++) begin
         d = 8'($urandom());
         i_rfsc_host_model.write(rfsc_pkg::SEP_LOW_ADDR, d);
         i_rfsc_host_model.write(rfsc_pkg::BIAS_ADDR, d);
         i_rfsc_host_model.write(rfsc_pkg::FRONT_ADDR, d);
         i_rfsc_host_model.write(rfsc_pkg::PA_ADDR, d);
         i_rfsc_host_model.write(rfsc_pkg::PLL_ADDR, d);
         @(negedge mclk_i);
         chk("sep", d, separation_low_bits_o);
         chk("bias", d, {osc_core_bias_o, mixer_buffer_drive_o,
             amp_buffer_drive_o});
         chk("front", d & 8'h3f, {2'b00, input_follower_stage_o,
             input_amp_bias_o, analog_pin_select_o,
             crystal_osc_off_o});
         chk("pa", d, {high_array_level_o, low_array_level_o});
         chk("pll", d & 8'hf8, {loop_filter_select_o,
             reference_divide_ratio_o, 3'b000});
         rd_chk(rfsc_pkg::SEP_LOW_ADDR, d, 1'b1);
         rd_chk(rfsc_pkg::BIAS_ADDR, d, 1'b1);
         rd_chk(rfsc_pkg::FRONT_ADDR, d & 8'h3f, 1'b1);
         rd_chk(rfsc_pkg::PA_ADDR, d, 1'b1);
         rd_chk(rfsc_pkg::PLL_ADDR, d & 8'hfc, 1'b1);
      end
      rd_chk(7'h0d, 8'h00, 1'b0);
      rd_chk(7'h07, 8'h00, 1'b0);
      $display("test readback done");
      for (int p = 0; p < 4; p++) begin
         i_rfsc_host_model.write(rfsc_pkg::FRONT_ADDR, 8'(p * 2));
         @(negedge mclk_i);
         chk("rssi", {7'h00, p == 1}, {7'h00, rssi_enable_o});
         chk("ifoff", {7'h00, p == 2}, {7'h00, internal_if_off_o});
      end
      rd_chk(rfsc_pkg::FRONT_ADDR, 8'h06, 1'b1);
      $display("test pin select done");
      i_rfsc_host_model.write(rfsc_pkg::PLL_ADDR, 8'h13);
      alarm_high_raw_i <= 1'b1;
      repeat (2) @(posedge mclk_i);
      chk("alarm_hi", 8'h01, {7'h00, alarm_high_o});
      rd_chk(rfsc_pkg::PLL_ADDR, 8'h12, 1'b1);
      alarm_high_raw_i <= 1'b0;
      alarm_low_raw_i  <= 1'b1;
      repeat (2) @(posedge mclk_i);
      chk("alarm_lo", 8'h01, {7'h00, alarm_low_o});
      rd_chk(rfsc_pkg::PLL_ADDR, 8'h11, 1'b1);
      i_rfsc_host_model.write(rfsc_pkg::PLL_ADDR, 8'h14);
      repeat (2) @(posedge mclk_i);
      chk("alarm_off", 8'h00, {7'h00, alarm_low_o});
      rd_chk(rfsc_pkg::PLL_ADDR, 8'h14, 1'b1);
      alarm_low_raw_i <= 1'b0;
      $display("test alarms done");
      for (int k = 0; k < 3; k++) begin
         i_rfsc_host_model.write(rfsc_pkg::PLL_ADDR, 8'h90);
         @(posedge mclk_i);
         break_loop_i <= (k < 2);
         fcomp_i      <= (k == 0);
         i_rfsc_host_model.write(rfsc_pkg::PLL_ADDR, 8'h10);
         #1;
         chk("svalid", {7'h00, k < 2}, {7'h00, comp_sample_valid_o});
         chk("sample", {7'h00, k == 0}, {7'h00, comp_sample_o});
      end
      $display("test comparator sample done");
      foreach (c_tab[j]) begin
         i_rfsc_host_model.write(rfsc_pkg::PLL_ADDR, {1'b0, c_tab[j], 3'h0});
         wait_tick(c);
         wait_tick(c);
         wait_tick(c);
         chk("period", n_tab[j], 8'(c));
      end
      $display("test divider done");
      i_rfsc_host_model.write(rfsc_pkg::SEP_LOW_ADDR, 8'ha5);
      main_reset_n_i <= 1'b0;
      i_rfsc_host_model.write(rfsc_pkg::SEP_LOW_ADDR, 8'h3c);
      chk("sep_rst", 8'h59, separation_low_bits_o);
      main_reset_n_i <= 1'b1;
      defaults_chk();
      i_rfsc_host_model.write(rfsc_pkg::SEP_LOW_ADDR, 8'h3c);
      @(negedge mclk_i);
      chk("sep_after", 8'h3c, separation_low_bits_o);
      $display("test main reset done");
      i_rfsc_host_model.power_down();
      rd_chk(rfsc_pkg::PA_ADDR, 8'h00, 1'b1);
      repeat (3) @(posedge mclk_i);
      chk("pending", 8'h00, 8'(exp_q.size()));
      $display("test power down done");
      final_report();
   end
endmodule : rfsc_regs_tb_top
